// >>> rtl/ndef_formatter.sv
// How it works
// - Program system code 0x12FC before any message exchange.
// - Attribute block lives in block 0 at byte address zero.
// - Message blocks 1..23, block n at byte address n times sixteen.
// - Byte 0 holds the mapping version, example 0x10.
// - Byte 1 holds read block limit fifteen.
// - Byte 2 holds write block limit eleven.
// - Bytes 3..4 max block count at most 23 when shared.
// - Type3 only use allows up to 26 blocks.
// - Encrypted configuration may limit the count to 24 blocks.
// - Bytes 5..8 are written as zero.
// - Write-in-progress byte 9 set 0x0F before, 0x00 after message.
// - Byte 10 access flag: 0x00 read-only, 0x01 read and write.
// - Bytes 11..13 hold message length; empty message gives three.
// - Bytes 14..15 checksum equals sum of bytes 0..13.
// - Empty message is 0xD00000 at start of block 1.
`timescale 1ns/1ps

module ndef_formatter
  import ndef_fmt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Device memory port
  output dev_req_s         dev_req_o,
  output logic             dev_valid_o,
  input  wire logic        dev_ack_i,
  input  wire logic        dev_err_i
);

  // ==========================================================
  // Attribute block builder
  // ==========================================================
  function automatic logic [127:0] build_aib(
    input logic [7:0]  ver,
    input logic [15:0] nmaxb,
    input logic [7:0]  wip,
    input logic [7:0]  acc,
    input logic [23:0] len
  );
    logic [127:0] blk;
    logic [15:0]  sum;
    blk = '0;
    sum = 16'h0000;
    blk[127:120] = ver;
    blk[119:112] = RD_LIMIT;
    blk[111:104] = WR_LIMIT;
    blk[103:88]  = nmaxb;
    blk[87:56]   = UNUSED_ZERO;
    blk[55:48]   = wip;
    blk[47:40]   = acc;
    blk[39:16]   = len;
    for (int i = 0; i < CSUM_BYTES; i++) begin
      sum = sum + {8'h00, blk[127-8*i -: 8]};
    end
    blk[15:0]    = sum;
    return blk;
  endfunction : build_aib

  // ==========================================================
  // Device answer synchronisers
  // ==========================================================
  logic ack_meta;
  logic ack_s;
  logic err_meta;
  logic err_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_meta <= 1'b0;
      ack_s    <= 1'b0;
      err_meta <= 1'b0;
      err_s    <= 1'b0;
    end else begin
      ack_meta <= dev_ack_i;
      ack_s    <= ack_meta;
      err_meta <= dev_err_i;
      err_s    <= err_meta;
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  logic        t3_only;
  logic        enc_limit;
  logic        read_only;
  logic [15:0] nmaxb;
  logic [7:0]  version;
  logic        busy;
  logic        done;
  logic        range_err;
  logic        dev_err;
  logic [15:0] last_csum;

  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req    = bus_req & wb_we_i;
  wire hit_ctrl  = wb_adr_i == REG_CTRL;
  wire hit_cfg   = wb_adr_i == REG_CONFIG;
  wire hit_sts   = wb_adr_i == REG_STATUS;
  wire wr_ctrl   = wr_req & hit_ctrl & wb_sel_i[0];
  wire wr_cfg_lo = wr_req & hit_cfg & wb_sel_i[0];
  wire wr_cfg_hi = wr_req & hit_cfg & wb_sel_i[1];
  wire wr_cfg_ve = wr_req & hit_cfg & wb_sel_i[2];
  wire start_hit = wr_ctrl & wb_dat_i[CTRL_START_BIT] & ~busy;

  // Limit picked from the chosen mapping mode
  // encrypted limit wins over Type3 only, else shared limit
  wire [15:0] nmaxb_cap = enc_limit ? NMAXB_ENC :
                          t3_only   ? NMAXB_T3  : NMAXB_SHARED;
  wire        nmaxb_bad = (nmaxb > nmaxb_cap) | (nmaxb == 16'h0000);

  wire [31:0] ctrl_rd = {28'h0000000, read_only, enc_limit, t3_only, 1'b0};
  wire [31:0] cfg_rd  = {8'h00, version, nmaxb};
  wire [31:0] sts_rd  = {last_csum, 12'h000, dev_err, range_err, done, busy};
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_cfg  ? cfg_rd  :
                        hit_sts  ? sts_rd  : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t3_only   <= 1'b0;
      enc_limit <= 1'b0;
      read_only <= 1'b0;
      nmaxb     <= NMAXB_RST;
      version   <= VER_RST;
    end else begin
      if (wr_ctrl && !busy) begin
        t3_only   <= wb_dat_i[CTRL_T3ONLY_BIT];
        enc_limit <= wb_dat_i[CTRL_ENC_BIT];
        read_only <= wb_dat_i[CTRL_RO_BIT];
      end
      if (wr_cfg_lo && !busy) begin
        nmaxb[7:0] <= wb_dat_i[CFG_NMAXB_LSB +: 8];
      end
      if (wr_cfg_hi && !busy) begin
        nmaxb[15:8] <= wb_dat_i[CFG_NMAXB_LSB+8 +: 8];
      end
      if (wr_cfg_ve && !busy) begin
        version <= wb_dat_i[CFG_VER_LSB +: 8];
      end
    end
  end

  // ==========================================================
  // Formatting sequence
  // ==========================================================
  fmt_state_e state;
  fmt_state_e seq_next;
  fmt_state_e next_state;
  dev_req_s   next_req;

  wire [7:0]   acc_val   = read_only ? ACC_RO : ACC_RW;
  wire [127:0] aib_open  = build_aib(version, nmaxb, WIP_SET, acc_val,
                                     EMPTY_LEN);
  wire [127:0] aib_close = build_aib(version, nmaxb, WIP_CLR, acc_val,
                                     EMPTY_LEN);

  always_comb begin
    unique case (state)
      S_IDLE:      seq_next = S_SYS;
      S_SYS:       seq_next = S_AIB_OPEN;
      S_AIB_OPEN:  seq_next = S_MSG;
      S_MSG:       seq_next = S_AIB_CLOSE;
      S_AIB_CLOSE: seq_next = S_IDLE;
      default:     seq_next = S_IDLE;
    endcase
  end

  // Device error aborts; no point closing a half-written image.
  // Only the flag latched together with an ack counts: the error line
  // means nothing between answers, and a flag left from an earlier
  // run must not turn a fresh start into an empty request.
  // stop on device error
  wire abort = dev_err & (state != S_IDLE);
  assign next_state = abort ? S_IDLE : seq_next;

  always_comb begin
    next_req = '0;
    unique case (next_state)
      S_SYS: begin
        next_req.op         = OP_SYS_CODE;
        next_req.data[15:0] = SYS_CODE_NDEF;
      end
      S_AIB_OPEN: begin
        next_req.op   = OP_BLOCK_WR;
        next_req.addr = {AIB_BLOCK, 4'h0};
        next_req.data = aib_open;
      end
      S_MSG: begin
        next_req.op            = OP_BLOCK_WR;
        next_req.addr          = 9'(MSG_FIRST_BLOCK) << BLOCK_SHIFT;
        next_req.data[127:104] = EMPTY_MSG;
      end
      S_AIB_CLOSE: begin
        next_req.op   = OP_BLOCK_WR;
        next_req.addr = {AIB_BLOCK, 4'h0};
        next_req.data = aib_close;
      end
      default: next_req = '0;
    endcase
  end

  // Four-phase handshake: hold until ack, drop, wait for ack release
  // Waiting for the synced ack to fall keeps a slow device from
  // seeing its old ack taken as the answer to the next request
  wire ack_seen  = dev_valid_o & ack_s;
  wire released  = ~dev_valid_o & ~ack_s & (state != S_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= S_IDLE;
      dev_valid_o <= 1'b0;
      dev_req_o   <= '0;
      busy        <= 1'b0;
    end else if (state == S_IDLE) begin
      if (start_hit && !nmaxb_bad) begin
        state       <= next_state;
        dev_valid_o <= 1'b1;
        dev_req_o   <= next_req;
        busy        <= 1'b1;
      end
    end else if (ack_seen) begin
      dev_valid_o <= 1'b0;
    end else if (released) begin
      state       <= next_state;
      dev_valid_o <= next_state != S_IDLE;
      dev_req_o   <= next_req;
      busy        <= next_state != S_IDLE;
    end
  end

  // Status flags; start only happens while idle, so set and clear
  // never meet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done      <= 1'b0;
      range_err <= 1'b0;
      dev_err   <= 1'b0;
      last_csum <= 16'h0000;
    end else begin
      if (start_hit) begin
        done      <= 1'b0;
        dev_err   <= 1'b0;
        range_err <= nmaxb_bad;
      end
      if (ack_seen && err_s) begin
        dev_err <= 1'b1;
      end
      if (released && next_state == S_IDLE) begin
        done <= 1'b1;
      end
      if (released && state == S_AIB_CLOSE) begin
        last_csum <= aib_close[15:0];
      end
    end
  end

endmodule : ndef_formatter

// >>> rtl/ndef_fmt_pkg.sv
package ndef_fmt_pkg;

  // ==========================================================
  // Software register map (word aligned byte addresses)
  // ==========================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Control bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_T3ONLY_BIT = 1;
  localparam int CTRL_ENC_BIT   = 2;
  localparam int CTRL_RO_BIT    = 3;

  // Config fields
  localparam int CFG_NMAXB_LSB = 0;
  localparam int CFG_VER_LSB   = 16;

  // Status bits
  localparam int STS_BUSY_BIT   = 0;
  localparam int STS_DONE_BIT   = 1;
  localparam int STS_RANGE_BIT  = 2;
  localparam int STS_DEVERR_BIT = 3;
  localparam int STS_CSUM_LSB   = 16;

  // Reset values
  localparam logic [15:0] NMAXB_RST = 16'h0017;
  localparam logic [7:0]  VER_RST   = 8'h10;

  // ==========================================================
  // Memory layout
  // ==========================================================
  localparam logic [15:0] SYS_CODE_NDEF   = 16'h12FC;
  localparam logic [4:0]  AIB_BLOCK       = 5'h00;
  localparam logic [4:0]  MSG_FIRST_BLOCK = 5'h01;
  localparam logic [4:0]  MSG_LAST_BLOCK  = 5'h17;
  localparam int          BLOCK_SHIFT     = 4;
  localparam int          AIB_BYTES       = 16;
  localparam int          CSUM_BYTES      = 14;

  // Attribute field values
  localparam logic [7:0]  RD_LIMIT     = 8'h0F;
  localparam logic [7:0]  WR_LIMIT     = 8'h0B;
  localparam logic [15:0] NMAXB_SHARED = 16'h0017;
  localparam logic [15:0] NMAXB_T3     = 16'h001A;
  localparam logic [15:0] NMAXB_ENC    = 16'h0018;
  localparam logic [31:0] UNUSED_ZERO  = 32'h00000000;
  localparam logic [7:0]  WIP_SET      = 8'h0F;
  localparam logic [7:0]  WIP_CLR      = 8'h00;
  localparam logic [7:0]  ACC_RO       = 8'h00;
  localparam logic [7:0]  ACC_RW       = 8'h01;
  localparam logic [23:0] EMPTY_LEN    = 24'h000003;
  localparam logic [23:0] EMPTY_MSG    = 24'hD00000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    OP_IDLE       = 2'b00,
    OP_SYS_CODE   = 2'b01,
    OP_BLOCK_WR   = 2'b10
  } dev_op_e;

  typedef struct packed {
    dev_op_e      op;
    logic [8:0]   addr;
    logic [127:0] data;
  } dev_req_s;

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_SYS       = 3'b001,
    S_AIB_OPEN  = 3'b010,
    S_MSG       = 3'b011,
    S_AIB_CLOSE = 3'b100
  } fmt_state_e;

endpackage : ndef_fmt_pkg

// >>> dv/ndef_formatter_asserts.sv
`timescale 1ns/1ps
module ndef_formatter_asserts
  import ndef_fmt_pkg::*;
(
  // Observed ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input dev_req_s         dev_req_o,
  input wire logic        dev_valid_o,
  input wire logic        dev_ack_i,
  input wire logic        dev_err_i
);
  // ==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [127:0] d = dev_req_o.data;
  wire logic wr = dev_valid_o && dev_req_o.op == OP_BLOCK_WR;
  wire logic attribute_info_block = wr && dev_req_o.addr == 9'h000;
  logic [15:0] sum;
  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < 14; i++) sum = sum + {8'h00, d[127-8*i -: 8]};
  end
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_req_hold: assert property (dev_valid_o && !dev_ack_i |=> dev_valid_o
    && $stable(dev_req_o)) else $error("request changed before ack");
  a_valid_release: assert property ($rose(dev_ack_i) && dev_valid_o |->
    ##[1:4] !dev_valid_o) else $error("request not released");
  a_sys_code: assert property (
    dev_valid_o && dev_req_o.op == OP_SYS_CODE |-> d[15:0] == 16'h12FC)
    else $error("system code value wrong");
  a_block_align: assert property (wr |-> dev_req_o.addr[3:0] == 4'h0 &&
    dev_req_o.addr <= 9'h170) else $error("block address wrong");
  a_aib_limits: assert property (attribute_info_block |-> d[119:112] == 8'h0F &&
    d[111:104] == 8'h0B && d[87:56] == 32'h0) else $error("limits wrong");
  a_nmaxb_cap: assert property (attribute_info_block |-> d[103:88] != 16'h0 &&
    d[103:88] <= 16'h001A) else $error("max block count out of range");
  a_aib_flags: assert property (attribute_info_block |-> d[55:48] inside {8'h0F, 8'h00} &&
    d[47:40] inside {8'h00, 8'h01} && d[39:16] == 24'h000003)
    else $error("attribute flags wrong");
  a_aib_sum: assert property (attribute_info_block |-> d[15:0] == sum)
    else $error("attribute checksum wrong");
  a_msg_empty: assert property (wr && dev_req_o.addr != 9'h000 |->
    dev_req_o.addr == 9'h010 && d == {24'hD00000, 104'h0})
    else $error("empty message wrong");
endmodule : ndef_formatter_asserts

bind ndef_formatter ndef_formatter_asserts u_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .dev_req_o, .dev_valid_o, .dev_ack_i, .dev_err_i);

// >>> dv/ndef_dev_model.sv
`timescale 1ns/1ps
module ndef_dev_model
  import ndef_fmt_pkg::*;
(
  // Host side
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  dev_req_s        req_i,
  input  wire logic       valid_i,
  // Bench control
  input  wire logic [3:0] lat_i,
  input  wire logic       fail_i,
  // Answer
  output logic            ack_o,
  output logic            err_o
);
  // ==========================================================
  // Memory and handshake
  logic [127:0] mem [32];
  logic [15:0]  sys_code;
  logic [7:0]   wip_seen;
  logic [3:0]   cnt;
  // misaligned or empty request answered with error
  wire logic bad = req_i.addr[3:0] != 4'h0 || req_i.op == OP_IDLE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      cnt <= 4'h0;
      sys_code <= 16'h0000;
    end else if (!valid_i) begin
      // Error line meaningless here, so keep it moving
      ack_o <= 1'b0;
      err_o <= ~err_o;
      cnt <= 4'h0;
    end else if (cnt < lat_i) begin
      cnt <= cnt + 4'h1;
    end else if (!ack_o) begin
      ack_o <= 1'b1;
      err_o <= fail_i || bad;
      if (!fail_i && !bad && req_i.op == OP_SYS_CODE) sys_code <= req_i.data[15:0];
      if (!fail_i && !bad && req_i.op == OP_BLOCK_WR) begin
        mem[req_i.addr[8:4]] <= req_i.data;
        if (req_i.addr[8:4] == 5'h01) wip_seen <= mem[0][55:48];
      end
    end
  end
endmodule : ndef_dev_model

// >>> dv/tb_ndef_formatter.sv
`timescale 1ns/1ps
module tb_ndef_formatter
  import ndef_fmt_pkg::*;
;
  // ==========================================================
  // Bench
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fail = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, lat = 0;
  logic [31:0] dat = 0, q, s = 5551, wb_dat_o;
  logic        wb_ack_o, dev_valid_o, dev_ack_i, dev_err_i;
  dev_req_s    dev_req_o;
  int          n_mismatch = 0, compares = 0;
  localparam logic [18:0] CORNER [8] = '{19'h00000, 19'h00017, 19'h00018,
    19'h1001A, 19'h1001B, 19'h30018, 19'h30019, 19'h40005};
  always #5 clk_i = ~clk_i;
  ndef_formatter u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o, .wb_ack_o, .dev_req_o, .dev_valid_o, .dev_ack_i, .dev_err_i);
  ndef_dev_model u_dev (.clk_i, .rst_i, .req_i(dev_req_o),
    .valid_i(dev_valid_o), .lat_i(lat), .fail_i(fail), .ack_o(dev_ack_i),
    .err_o(dev_err_i));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic [127:0] attribute_info_block(logic [7:0] v, logic [15:0] n,
                                       logic [7:0] a);
    logic [127:0] b;
    logic [15:0]  c;
    b = {v, 8'h0F, 8'h0B, n, 32'h0, 8'h00, a, 24'h000003, 16'h0};
    c = 16'h0000;
    for (int i = 0; i < 14; i++) c = c + {8'h00, b[127-8*i -: 8]};
    return {b[127:16], c};
  endfunction : attribute_info_block
  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] m);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= m;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    if (n >= 20) begin
      n_mismatch++;
      summarize();
    end
    @(posedge clk_i);
  endtask : wb
  // Mode bits: ro, enc, t3; start goes in a second write
  task automatic run(logic [2:0] mode, logic [7:0] v, logic [15:0] n);
    logic [15:0]  cap;
    logic         bad;
    logic [127:0] exp;
    int           k;
    cap = mode[1] ? 16'h0018 : mode[0] ? 16'h001A : 16'h0017;
    bad = n == 16'h0 || n > cap;
    exp = attribute_info_block(v, n, mode[2] ? ACC_RO : ACC_RW);
    wb(1, REG_CONFIG, {8'h00, v, n}, 4'h7);
    wb(1, REG_CTRL, {28'h0, mode, 1'b0}, 4'h1);
    wb(1, REG_CTRL, {28'h0, mode, 1'b1}, 4'h1);
    k = 0;
    do begin
      wb(0, REG_STATUS, 32'h0, 4'hF);
      k++;
    end while (q[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_mismatch++;
      summarize();
    end
    check("range", bad, q[2]);
    if (!bad) check("status", {fail, 2'b01}, q[3:1]);
    if (!bad && !fail) begin
      check("csum", exp[15:0], q[31:16]);
      check("aib", exp, u_dev.mem[0]);
      check("msg", {24'hD00000, 104'h0}, u_dev.mem[1]);
      check("wip", WIP_SET, u_dev.wip_seen);
      check("sys", 16'h12FC, u_dev.sys_code);
    end
    $display("test mode %b count %h done", mode, n);
  endtask : run
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, REG_CONFIG, 32'h0, 4'hF);
    check("config", {8'h00, VER_RST, NMAXB_RST}, q);
    wb(0, REG_STATUS, 32'h0, 4'hF);
    check("status_rst", 32'h0, q);
    wb(1, 8'hFC, 32'hFFFFFFFF, 4'hF);
    wb(0, 8'hFC, 32'h0, 4'hF);
    check("unmapped", 32'h0, q);
    run(3'b000, VER_RST, NMAXB_RST);
    check("csum_default", 16'h0045, q[31:16]);
    foreach (CORNER[i]) run(CORNER[i][18:16], VER_RST, CORNER[i][15:0]);
    for (int i = 0; i < 12; i++) begin
      lat <= 4'(rnd());
      run(3'(rnd()), 8'(rnd()), 16'(rnd() % 32'h1C));
    end
    fail <= 1;
    run(3'b000, VER_RST, NMAXB_RST);
    summarize();
  end
endmodule : tb_ndef_formatter
